// File: design/pdvsc_defs.vh
/*
  Constants for the power domain and voltage scaling controller.
  Assumes it is included by bare name from the design files.
*/
`ifndef PDVSC_DEFS_VH
`define PDVSC_DEFS_VH

`define PDVSC_MODE_W 3
`define PDVSC_MODE_ACTIVE 3'h0
`define PDVSC_MODE_SLEEP 3'h1
`define PDVSC_MODE_DEEP_SLEEP 3'h2
`define PDVSC_MODE_STOP 3'h3
`define PDVSC_MODE_HIBERNATE 3'h4

`define PDVSC_SCALE_W 2
`define PDVSC_SCALE_LOW 2'h0
`define PDVSC_SCALE_MID 2'h1
`define PDVSC_SCALE_FULL 2'h2

`define PDVSC_MID_MAX_MHZ 40
`define PDVSC_AUX_N 3
`define PDVSC_AUX_W 4

`define PDVSC_PWR_ACTIVE 1'h1
`define PDVSC_PWR_RESET 1'h0

`endif

// File: design/pdvsc_aux_gate.v
/*
  Decides the power of the auxiliary low-power domains from the mode class
  and the per-domain peripheral enable requests.
  Assumes the mode class inputs are decoded combinationally by the caller from an energy mode on its clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pdvsc_aux_gate #(
  parameter AUX_N = 3
) (
  input wire low_class,
  input wire hib_class,
  input wire [AUX_N-1:0] aux_req,
  input wire shared_req,
  output wire [AUX_N-1:0] aux_on,
  output wire shared_on
);

  assign aux_on = (low_class && !hib_class) ? aux_req : {AUX_N{1'b0}};

  assign shared_on = low_class && !hib_class && (shared_req || (|aux_on));

endmodule // pdvsc_aux_gate

`default_nettype wire

// File: design/pdvsc_ctrl.v
/*
  Power domain and voltage scaling controller: turns the energy mode and the
  peripheral enable requests into domain power controls and a target scale.
  Assumes energy mode, requests and scale selections come from logic on clk;
  they are therefore not synchronised.
*/
// What this block does
// - Always-on domain stays powered in every mode.
// - Hibernate powers down all low-power domains.
// - Base low domain on in modes zero-three.
// - Deep sleep/stop: powered aux when peripheral enabled.
// - Deep sleep/stop: unused aux domain powered down.
// - Shared aux on when any other aux on.
// - Active domain on in active and sleep.
// - Active domain off in deeper modes.
// - Unassigned peripherals belong to active domain.
// - Domain switching is automatic, no software steps.
// - Two independent voltage scale selections held.
// - Active/sleep selection resets to full scale.
// - Mid scale allowed, core at most 40MHz.
// - Low scale selectable for deep sleep/stop.
// - Target scale follows selection of new mode.
`timescale 1ns/1ps
`default_nettype none
`include "pdvsc_defs.vh"

module pdvsc_ctrl #(
  parameter AUX_N = `PDVSC_AUX_N
) (
  input wire clk,
  input wire rst_b,
  input wire [`PDVSC_MODE_W-1:0] energy_mode,
  input wire [AUX_N-1:0] aux_req,
  input wire shared_req,
  input wire active_periph_req,
  input wire [`PDVSC_SCALE_W-1:0] run_scale_sel,
  input wire run_scale_wr,
  input wire [`PDVSC_SCALE_W-1:0] low_scale_sel,
  input wire low_scale_wr,
  output reg always_on_domain_r,
  output reg base_low_domain_r,
  output reg [AUX_N-1:0] aux_domain_r,
  output reg shared_aux_domain_r,
  output reg active_domain_r,
  output reg active_periph_on_r,
  output reg [`PDVSC_SCALE_W-1:0] target_scale_r,
  output wire [`PDVSC_SCALE_W-1:0] run_scale_r_out,
  output wire [`PDVSC_SCALE_W-1:0] low_scale_r_out,
  output reg mode_change_r
);

  reg [`PDVSC_SCALE_W-1:0] run_scale_r;
  reg [`PDVSC_SCALE_W-1:0] low_scale_r;
  reg [`PDVSC_MODE_W-1:0] last_mode_r;
  wire run_class;
  wire low_class;
  wire hib_class;
  wire [AUX_N-1:0] aux_nxt;
  wire shared_nxt;
  reg [`PDVSC_SCALE_W-1:0] target_nxt;

  function legal_scale;
    input [`PDVSC_SCALE_W-1:0] s;
    begin
      legal_scale = (s == `PDVSC_SCALE_LOW) || (s == `PDVSC_SCALE_MID) ||
                    (s == `PDVSC_SCALE_FULL);
    end
  endfunction

  // Unknown mode codes are treated as hibernate, the safest state.
  assign run_class = (energy_mode == `PDVSC_MODE_ACTIVE) ||
                     (energy_mode == `PDVSC_MODE_SLEEP);
  assign low_class = (energy_mode == `PDVSC_MODE_DEEP_SLEEP) ||
                     (energy_mode == `PDVSC_MODE_STOP);
  assign hib_class = !run_class && !low_class;

  pdvsc_aux_gate #(
    .AUX_N(AUX_N)
  ) u_aux_gate (
    .low_class(low_class),
    .hib_class(hib_class),
    .aux_req(aux_req),
    .shared_req(shared_req),
    .aux_on(aux_nxt),
    .shared_on(shared_nxt)
  );

  always @*
  begin
    if (run_class)
    begin
      target_nxt = run_scale_r;
    end
    else if (low_class)
    begin
      target_nxt = low_scale_r;
    end
    else
    begin
      target_nxt = low_scale_r;
    end
  end

  assign run_scale_r_out = run_scale_r;
  assign low_scale_r_out = low_scale_r;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      run_scale_r <= `PDVSC_SCALE_FULL;
      low_scale_r <= `PDVSC_SCALE_LOW;
    end
    else
    begin
      if (run_scale_wr && legal_scale(run_scale_sel))
      begin
        run_scale_r <= run_scale_sel;
      end
      if (low_scale_wr && legal_scale(low_scale_sel))
      begin
        low_scale_r <= low_scale_sel;
      end
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      always_on_domain_r <= `PDVSC_PWR_ACTIVE;
      base_low_domain_r <= `PDVSC_PWR_ACTIVE;
      aux_domain_r <= {AUX_N{1'b0}};
      shared_aux_domain_r <= `PDVSC_PWR_RESET;
      active_domain_r <= `PDVSC_PWR_ACTIVE;
      active_periph_on_r <= `PDVSC_PWR_RESET;
      target_scale_r <= `PDVSC_SCALE_FULL;
      last_mode_r <= `PDVSC_MODE_ACTIVE;
      mode_change_r <= 1'b0;
    end
    else
    begin
      always_on_domain_r <= `PDVSC_PWR_ACTIVE;
      base_low_domain_r <= !hib_class;
      aux_domain_r <= aux_nxt;
      shared_aux_domain_r <= shared_nxt;
      active_domain_r <= run_class;
      active_periph_on_r <= run_class && active_periph_req;
      target_scale_r <= target_nxt;
      last_mode_r <= energy_mode;
      mode_change_r <= (energy_mode != last_mode_r);
    end
  end

endmodule // pdvsc_ctrl

`default_nettype wire

// File: verif/pdvsc_checker.sv
/* Checker for the domain power controller ports.
   Assumes it is bound to pdvsc_ctrl with three auxiliary domains. */
`timescale 1ns/1ps
`default_nettype none
module pdvsc_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] energy_mode,
  input wire logic [2:0] aux_req,
  input wire logic shared_req,
  input wire logic active_periph_req,
  input wire logic [1:0] run_scale_sel,
  input wire logic run_scale_wr,
  input wire logic [1:0] low_scale_sel,
  input wire logic low_scale_wr,
  input wire logic always_on_domain_r,
  input wire logic base_low_domain_r,
  input wire logic [2:0] aux_domain_r,
  input wire logic shared_aux_domain_r,
  input wire logic active_domain_r,
  input wire logic active_periph_on_r,
  input wire logic [1:0] target_scale_r,
  input wire logic [1:0] run_scale_r_out,
  input wire logic [1:0] low_scale_r_out
);
  wire run_m = energy_mode < 3'h2;
  wire lp_m = energy_mode == 3'h2 || energy_mode == 3'h3;
  wire sh_on = lp_m && (shared_req || |aux_req);
  wire per_on = run_m && active_periph_req;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  aon_on_a: assert property (always_on_domain_r) else $error("aon off");
  hib_off_a: assert property (energy_mode > 3'h3 |=> !base_low_domain_r && aux_domain_r == 3'h0
    && !shared_aux_domain_r) else $error("hib");
  base_on_a: assert property (energy_mode < 3'h4 |=> base_low_domain_r) else $error("base");
  aux_req_a: assert property (1 |=> aux_domain_r == ($past(lp_m) ? $past(aux_req) : 3'h0))
    else $error("aux");
  shared_on_a: assert property (1 |=> shared_aux_domain_r == $past(sh_on)) else $error("shr");
  act_dom_a: assert property (1 |=> active_domain_r == $past(run_m)) else $error("act");
  periph_dom_a: assert property (1 |=> active_periph_on_r == $past(per_on)) else $error("per");
  target_sel_a: assert property (!run_scale_wr && !low_scale_wr |=> target_scale_r ==
    ($past(run_m) ? run_scale_r_out : low_scale_r_out)) else $error("tgt");
  run_wr_a: assert property (run_scale_wr && run_scale_sel != 2'h3 |=>
    run_scale_r_out == $past(run_scale_sel)) else $error("wr");
  low_wr_a: assert property (low_scale_wr && low_scale_sel != 2'h3 |=>
    low_scale_r_out == $past(low_scale_sel)) else $error("lwr");
  low_ign_a: assert property (low_scale_wr && low_scale_sel == 2'h3 |=>
    $stable(low_scale_r_out)) else $error("ign");
endmodule // pdvsc_checker
`default_nettype wire

// File: verif/pdvsc_ctrl_tb_top.sv
/* Directed bench for the domain power controller.
   Assumes the checker module is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pdvsc_ctrl_tb_top;
  logic clk = 0, rst_b = 0, sq = 0, pq = 1, rw = 0, lw = 0;
  logic [2:0] md = 0, aq = 0, ad;
  logic [1:0] rs = 0, ls = 0, tg, ro, lo;
  logic ao, bs, sh, ac, ap, mc;
  int failures = 0, check_count = 0;
  pdvsc_ctrl pdvsc_ctrl_i (.clk(clk), .rst_b(rst_b), .energy_mode(md), .aux_req(aq),
    .shared_req(sq), .active_periph_req(pq), .run_scale_sel(rs), .run_scale_wr(rw),
    .low_scale_sel(ls), .low_scale_wr(lw), .always_on_domain_r(ao), .base_low_domain_r(bs),
    .aux_domain_r(ad), .shared_aux_domain_r(sh), .active_domain_r(ac), .active_periph_on_r(ap),
    .target_scale_r(tg), .run_scale_r_out(ro), .low_scale_r_out(lo), .mode_change_r(mc));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task t_modes;
    for (int m = 0; m < 5; m++)
    begin
      @(negedge clk);
      md = m[2:0];
      aq = 3'h2;
      pq = m[0];
      @(negedge clk);
      chk({bs, ad, sh, ac}, {m < 4, (m == 2 || m == 3) ? 3'h2 : 3'h0, m == 2 || m == 3, m < 2});
      chk({ao, tg, ap}, {1'b1, m < 2 ? 2'h2 : 2'h0, m == 1});
      chk(mc, m != 0);
    end
  endtask
  task t_aux;
    for (int r = 0; r < 16; r++)
    begin
      @(negedge clk);
      md = r[0] ? 3'h3 : 3'h2;
      aq = r[2:0];
      sq = r[3];
      @(negedge clk);
      chk({ad, sh}, {r[2:0], r[3] || (r[2:0] != 3'h0)});
    end
  endtask
  task t_scale;
    @(negedge clk);
    md = 3'h0;
    rs = 2'h1;
    rw = 1;
    ls = 2'h3;
    lw = 1;
    @(negedge clk);
    rw = 0;
    lw = 0;
    @(negedge clk);
    chk({ro, lo, tg}, 8'h11);
    chk(mc, 8'h00);
    md = 3'h3;
    @(negedge clk);
    chk(tg, 8'h00);
    ls = 2'h2;
    lw = 1;
    @(negedge clk);
    lw = 0;
    md = 3'h1;
    @(negedge clk);
    chk({lo, tg}, 8'h09);
    md = 3'h2;
    @(negedge clk);
    chk(tg, 8'h02);
  endtask
  task t_reset;
    @(negedge clk);
    rst_b = 0;
    @(negedge clk);
    chk({tg, ro, lo, ac, ao}, 8'ha3);
    chk({bs, ad, sh, ap, mc}, 8'h40);
    rst_b = 1;
    @(negedge clk);
    chk({ac, tg, mc}, 8'h01);
  endtask
  initial
  begin
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (3) @(negedge clk);
    chk({tg, ro, lo, ac, ao}, 8'ha3);
    rst_b = 1;
    t_modes;
    t_aux;
    t_scale;
    t_reset;
    give_verdict;
  end
endmodule // pdvsc_ctrl_tb_top
bind pdvsc_ctrl pdvsc_checker pdvsc_checker_i (.clk, .rst_b, .energy_mode, .aux_req, .shared_req,
  .active_periph_req, .run_scale_sel, .run_scale_wr, .low_scale_sel, .low_scale_wr,
  .always_on_domain_r, .base_low_domain_r, .aux_domain_r, .shared_aux_domain_r,
  .active_domain_r, .active_periph_on_r, .target_scale_r, .run_scale_r_out, .low_scale_r_out);
`default_nettype wire
